// ===== src/nfp_pkg.sv
/*
  Shared constants and types of the page-flash host controller: register map,
  command codes, strobe timing and the per-operation cycle plan.
  Assumes a 20 MHz system clock and a single AHB-Lite master.
*/
package nfp_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [31:0] REG_CTRL     = 32'h0000_0000;
  localparam logic [31:0] REG_START    = 32'h0000_0004;
  localparam logic [31:0] REG_COLUMN   = 32'h0000_0008;
  localparam logic [31:0] REG_ROW      = 32'h0000_000c;
  localparam logic [31:0] REG_COUNT    = 32'h0000_0010;
  localparam logic [31:0] REG_STATUS   = 32'h0000_0014;
  localparam logic [31:0] REG_BUF_PTR  = 32'h0000_0018;
  localparam logic [31:0] REG_BUF_DATA = 32'h0000_001c;

  localparam int CTRL_WP_BIT    = 0;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_RDY_BIT   = 1;
  localparam int STAT_REFUSED   = 2;
  localparam int STAT_DONE      = 3;
  localparam int STAT_LAST_LSB  = 8;
  localparam int OP_W           = 3;

  localparam int BUF_AW   = 6;
  localparam int BUF_DEPTH = 64;
  localparam int CNT_W    = 7;
  localparam int COL_W    = 12;
  localparam int ROW_W    = 16;

  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       RESP_OKAY  = 1'b0;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ADDR   = 8'h00;
  localparam logic [7:0] CMD_READ_GO     = 8'h30;
  localparam logic [7:0] CMD_COL_ADDR    = 8'h05;
  localparam logic [7:0] CMD_COL_GO      = 8'he0;
  localparam logic [7:0] CMD_PROG_DATA   = 8'h80;
  localparam logic [7:0] CMD_PROG_GO     = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO    = 8'hd0;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] CMD_RESET       = 8'hff;
  localparam logic [7:0] CMD_ID          = 8'h90;
  localparam logic [7:0] ID_ADDR         = 8'h00;
  localparam logic [3:0] COL_HI_PAD      = 4'h0;

  // Address byte order
  localparam logic [1:0] AB_COL_LO = 2'h0;
  localparam logic [1:0] AB_COL_HI = 2'h1;
  localparam logic [1:0] AB_ROW_LO = 2'h2;
  localparam logic [1:0] AB_ROW_HI = 2'h3;
  localparam logic [2:0] ADDR_NONE = 3'h0;
  localparam logic [2:0] ADDR_ONE  = 3'h1;
  localparam logic [2:0] ADDR_COL  = 3'h2;
  localparam logic [2:0] ADDR_FULL = 3'h4;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_NS  = 50;
  localparam int T_WW_NS = 100;
  localparam int T_WB_NS = 200;
  localparam logic [CNT_W-1:0] WW_CYC = CNT_W'((T_WW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WB_CYC = CNT_W'((T_WB_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] LEN_ONE = 7'h01;

  // ----------------------------------------------------------------------
  // Operations and sequencing
  // ----------------------------------------------------------------------
  typedef enum logic [OP_W-1:0] {
    OP_READ, OP_PROG, OP_ERASE, OP_STATUS, OP_RESET, OP_ID, OP_COLCHG
  } nfp_op_t;

  typedef enum {
    S_IDLE, S_SETUP, S_CMD1, S_ADDR, S_WDATA, S_CMD2, S_WAIT_WB, S_WAIT_RDY,
    S_RDATA
  } nfp_state_t;

  localparam logic [2:0] FROM_CMD1  = 3'h0;
  localparam logic [2:0] FROM_ADDR  = 3'h1;
  localparam logic [2:0] FROM_WDATA = 3'h2;
  localparam logic [2:0] FROM_CMD2  = 3'h3;
  localparam logic [2:0] FROM_WAIT  = 3'h4;
  localparam logic [2:0] FROM_RDATA = 3'h5;

  typedef struct packed {
    logic [7:0] cmd1;
    logic [2:0] naddr;
    logic       wdata;
    logic       has_cmd2;
    logic [7:0] cmd2;
    logic       wait_rdy;
    logic       rdata;
  } nfp_plan_t;

  function automatic nfp_plan_t plan_of(input nfp_op_t op);
    nfp_plan_t p;
    p = '{CMD_STATUS, ADDR_NONE, 1'b0, 1'b0, CMD_READ_ADDR, 1'b0, 1'b1};
    unique case (op)
      OP_READ:   p = '{CMD_READ_ADDR, ADDR_FULL, 1'b0, 1'b1, CMD_READ_GO, 1'b1, 1'b1};
      OP_PROG:   p = '{CMD_PROG_DATA, ADDR_FULL, 1'b1, 1'b1, CMD_PROG_GO, 1'b1, 1'b0};
      OP_ERASE:  p = '{CMD_ERASE_SETUP, ADDR_FULL, 1'b0, 1'b1, CMD_ERASE_GO, 1'b1, 1'b0};
      OP_STATUS: p = '{CMD_STATUS, ADDR_NONE, 1'b0, 1'b0, CMD_READ_ADDR, 1'b0, 1'b1};
      OP_RESET:  p = '{CMD_RESET, ADDR_NONE, 1'b0, 1'b0, CMD_READ_ADDR, 1'b1, 1'b0};
      OP_ID:     p = '{CMD_ID, ADDR_ONE, 1'b0, 1'b0, CMD_READ_ADDR, 1'b0, 1'b1};
      OP_COLCHG: p = '{CMD_COL_ADDR, ADDR_COL, 1'b0, 1'b1, CMD_COL_GO, 1'b0, 1'b1};
      default:   p = '{CMD_STATUS, ADDR_NONE, 1'b0, 1'b0, CMD_READ_ADDR, 1'b0, 1'b1};
    endcase
    return p;
  endfunction

endpackage

// ===== src/nfp_byte_mem.sv
/*
  Byte buffer of the page-flash host controller: one write port, one read
  port, read data registered.
  Assumes the caller never writes and reads one address in the same cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module nfp_byte_mem
  import nfp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              wr_en_i,
  input  wire logic [BUF_AW-1:0] wr_addr_i,
  input  wire logic [7:0]        wr_data_i,
  input  wire logic [BUF_AW-1:0] rd_addr_i,
  output logic      [7:0]        rd_data_o
);

  logic [7:0] mem [BUF_DEPTH];

  // Array has no reset; contents are undefined until written
  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
      mem[wr_addr_i] <= wr_data_i;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rd_data_o <= 8'h00;
    else
      rd_data_o <= mem[rd_addr_i];
  end

endmodule

`default_nettype wire

// ===== src/nfp_host.sv
/*
  Host controller for a page-organised NAND flash: AHB-Lite register slave,
  operation sequencer and strobe generator for the shared byte port.
  Assumes one AHB-Lite master with hready_i fed back from hreadyout_o, a
  pull-up on the ready/busy line, and a 20 MHz clk_i.
*/
// Behaviour
// - Write protect low blocks program/erase; host holds it high for them.
// - Address is four bytes: column low, column high padded, row low, row high.
// - Cycle type decoded at write strobe from latch selects, output strobe high.
// - Code 00 opens read address entry, code 30 starts the page read.
// - Codes 05, new column, E0 move the output pointer during serial out.
// - Code 80 opens program data input, 10 starts program; erase is 60 then D0.
// - Only status read and reset are issued while the device is busy.
// - Erase begins at write strobe rise after D0 following 60.
`timescale 1ns/10ps
`default_nettype none

module nfp_host
  import nfp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic      [31:0] hrdata_o,
  output logic             chip_select_n_o,
  output logic             cmd_latch_o,
  output logic             addr_latch_o,
  output logic             write_strobe_n_o,
  output logic             output_strobe_n_o,
  output logic             write_protect_n_o,
  input  wire logic [7:0]  shared_byte_port_i,
  output logic      [7:0]  shared_byte_port_o,
  output logic             shared_byte_port_oe_o,
  input  wire logic        ready_busy_n_i
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  nfp_state_t        state, next_state;
  nfp_op_t           op, next_op;
  logic              ph, next_ph;
  logic [CNT_W-1:0]  cnt, next_cnt, xfer_len, next_len, lim;
  logic [BUF_AW-1:0] ptr, next_ptr;
  logic [7:0]        last_byte, next_last, mem_rd, mem_wd;
  logic              mem_we;
  logic [2:0]        from;
  logic              wr_pend, next_wr_pend, rd_wait, next_rd_wait;
  logic [31:0]       wr_addr, next_wr_addr, next_hrdata;
  logic              next_hreadyout;
  logic              wp_allow, next_wp_allow, refused, next_refused;
  logic              done, next_done;
  logic [COL_W-1:0]  col, next_col;
  logic [ROW_W-1:0]  row, next_row;
  logic [CNT_W-1:0]  count, next_count;
  logic              next_cs_n, next_cle, next_ale, next_we_n, next_re_n;
  logic              next_wp_n, next_oe, wr_state;
  logic [7:0]        next_port;
  logic              acc, idle, start_req, start_bad, start_go, eng_end;
  logic              cnt_end, no_bytes;
  nfp_op_t           start_op;
  nfp_plan_t         plan;

  function automatic logic wr_to(input logic [31:0] a);
    return wr_pend && (wr_addr == a);
  endfunction

  function automatic logic [7:0] addr_byte(input logic [CNT_W-1:0] i);
    logic [7:0] b;
    b = ID_ADDR;
    if (op != OP_ID)
      unique case (i[1:0])
        AB_COL_LO: b = col[7:0];
        AB_COL_HI: b = {COL_HI_PAD, col[COL_W-1:8]};
        AB_ROW_LO: b = row[7:0];
        AB_ROW_HI: b = row[ROW_W-1:8];
      endcase
    return b;
  endfunction

  function automatic nfp_state_t follow(input logic [2:0] f);
    nfp_state_t s;
    s = S_IDLE;
    if (f < FROM_ADDR && plan.naddr != ADDR_NONE)
      s = S_ADDR;
    else if (f < FROM_WDATA && plan.wdata && !no_bytes)
      s = S_WDATA;
    else if (f < FROM_CMD2 && plan.has_cmd2)
      s = S_CMD2;
    else if (f < FROM_WAIT && plan.wait_rdy)
      s = S_WAIT_WB;
    else if (f < FROM_RDATA && plan.rdata && !no_bytes)
      s = S_RDATA;
    return s;
  endfunction

  function automatic logic [31:0] read_reg(input logic [31:0] a);
    logic [31:0] d;
    d = 32'h0;
    unique case (a)
      REG_CTRL:    d[CTRL_WP_BIT] = wp_allow;
      REG_START:   d[OP_W-1:0] = op;
      REG_COLUMN:  d[COL_W-1:0] = col;
      REG_ROW:     d[ROW_W-1:0] = row;
      REG_COUNT:   d[CNT_W-1:0] = count;
      REG_BUF_PTR: d[BUF_AW-1:0] = ptr;
      REG_STATUS:
      begin
        d[STAT_BUSY_BIT] = !idle;
        d[STAT_RDY_BIT] = ready_busy_n_i;
        d[STAT_REFUSED] = refused;
        d[STAT_DONE] = done;
        d[STAT_LAST_LSB +: 8] = last_byte;
      end
      default:     d = 32'h0;
    endcase
    return d;
  endfunction

  assign acc       = hsel_i && htrans_i[1] && hready_i && (hsize_i == HSIZE_WORD);
  assign idle      = (state == S_IDLE);
  assign plan      = plan_of(op);
  assign no_bytes  = (xfer_len == '0);
  assign start_req = wr_to(REG_START);
  assign start_op  = nfp_op_t'(hwdata_i[OP_W-1:0]);
  // Busy device accepts only status and reset; protected array refuses P/E
  assign start_bad = !idle || (hwdata_i[OP_W-1:0] > OP_COLCHG)
                   || (!ready_busy_n_i && !(start_op inside {OP_STATUS, OP_RESET}))
                   || (!wp_allow && (start_op inside {OP_PROG, OP_ERASE}));
  assign start_go  = start_req && !start_bad;
  assign eng_end   = !idle && (next_state == S_IDLE);

  nfp_byte_mem u_mem (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .wr_en_i   (mem_we),
    .wr_addr_i (ptr),
    .wr_data_i (mem_wd),
    .rd_addr_i (next_ptr),
    .rd_data_o (mem_rd)
  );

  // ----------------------------------------------------------------------
  // Bus slave and software registers
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_wr_pend   = acc && hwrite_i;
    next_wr_addr   = acc ? haddr_i : wr_addr;
    // Buffer reads take one wait state so a pointer write just before is seen
    next_rd_wait   = acc && !hwrite_i && (haddr_i == REG_BUF_DATA);
    next_hreadyout = !next_rd_wait;
    next_hrdata    = hrdata_o;
    if (rd_wait)
      next_hrdata = {24'h0, mem_rd};
    else if (acc && !hwrite_i)
      next_hrdata = read_reg(haddr_i);
    next_wp_allow = wr_to(REG_CTRL) ? hwdata_i[CTRL_WP_BIT] : wp_allow;
    next_col      = col;
    next_row      = row;
    next_count    = count;
    // Address fields are frozen while an operation uses them
    if (idle && wr_to(REG_COLUMN))
      next_col = hwdata_i[COL_W-1:0];
    if (idle && wr_to(REG_ROW))
      next_row = hwdata_i[ROW_W-1:0];
    if (idle && wr_to(REG_COUNT))
      next_count = hwdata_i[CNT_W-1:0];
    // Write one to clear; a new event in the same cycle wins
    next_refused = refused && !(wr_to(REG_STATUS) && hwdata_i[STAT_REFUSED]);
    next_done    = done && !(wr_to(REG_STATUS) && hwdata_i[STAT_DONE]);
    if (start_req && start_bad)
      next_refused = 1'b1;
    if (eng_end)
      next_done = 1'b1;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_pend     <= 1'b0;
      wr_addr     <= 32'h0;
      rd_wait     <= 1'b0;
      hreadyout_o <= 1'b1;
      hresp_o     <= RESP_OKAY;
      hrdata_o    <= 32'h0;
      wp_allow    <= 1'b0;
      col         <= '0;
      row         <= '0;
      count       <= '0;
      refused     <= 1'b0;
      done        <= 1'b0;
    end
    else
    begin
      wr_pend     <= next_wr_pend;
      wr_addr     <= next_wr_addr;
      rd_wait     <= next_rd_wait;
      hreadyout_o <= next_hreadyout;
      hresp_o     <= RESP_OKAY;
      hrdata_o    <= next_hrdata;
      wp_allow    <= next_wp_allow;
      col         <= next_col;
      row         <= next_row;
      count       <= next_count;
      refused     <= next_refused;
      done        <= next_done;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer and pin drive
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_op    = op;
    next_ph    = ph;
    next_cnt   = cnt;
    next_len   = xfer_len;
    next_ptr   = ptr;
    next_last  = last_byte;
    mem_we     = 1'b0;
    mem_wd     = hwdata_i[7:0];
    lim        = xfer_len;
    from       = FROM_RDATA;
    unique case (state)
      S_SETUP:   lim = WW_CYC;
      S_WAIT_WB: lim = WB_CYC;
      S_ADDR:    lim = CNT_W'(plan.naddr);
      default:   lim = xfer_len;
    endcase
    unique case (state)
      S_CMD1:  from = FROM_CMD1;
      S_ADDR:  from = FROM_ADDR;
      S_WDATA: from = FROM_WDATA;
      S_CMD2:  from = FROM_CMD2;
      default: from = FROM_RDATA;
    endcase
    cnt_end = (CNT_W'(cnt + 1'b1) == lim);
    unique case (state)
      S_IDLE:
      begin
        if (start_go)
        begin
          next_state = S_SETUP;
          next_op    = start_op;
          next_cnt   = '0;
          next_ptr   = '0;
          next_len   = (start_op == OP_STATUS) ? LEN_ONE : count;
        end
        else if (wr_to(REG_BUF_PTR))
          next_ptr = hwdata_i[BUF_AW-1:0];
        else if (wr_to(REG_BUF_DATA))
        begin
          mem_we   = 1'b1;
          next_ptr = ptr + 1'b1;
        end
        else if (rd_wait)
          next_ptr = ptr + 1'b1;
      end
      S_SETUP, S_WAIT_WB:
      begin
        next_cnt = CNT_W'(cnt + 1'b1);
        if (cnt_end)
        begin
          next_cnt   = '0;
          next_state = (state == S_SETUP) ? S_CMD1 : S_WAIT_RDY;
        end
      end
      S_WAIT_RDY:
        if (ready_busy_n_i)
          next_state = follow(FROM_WAIT);
      S_CMD1, S_ADDR, S_WDATA, S_CMD2, S_RDATA:
      begin
        next_ph = !ph;
        if (!ph && (state inside {S_WDATA, S_RDATA}))
          next_ptr = ptr + 1'b1;
        if (!ph && state == S_RDATA)
        begin
          // Device advances its own column, so no address is resent
          mem_we    = 1'b1;
          mem_wd    = shared_byte_port_i;
          next_last = shared_byte_port_i;
        end
        if (ph && !cnt_end && (state inside {S_ADDR, S_WDATA, S_RDATA}))
          next_cnt = CNT_W'(cnt + 1'b1);
        else if (ph)
        begin
          next_cnt   = '0;
          next_state = follow(from);
        end
      end
    endcase

    wr_state  = next_state inside {S_CMD1, S_ADDR, S_WDATA, S_CMD2};
    next_cs_n = (next_state == S_IDLE);
    next_cle  = next_state inside {S_CMD1, S_CMD2};
    next_ale  = (next_state == S_ADDR);
    next_we_n = !(wr_state && !next_ph);
    next_re_n = !(next_state == S_RDATA && !next_ph);
    next_oe   = wr_state;
    next_wp_n = next_wp_allow
             || (next_state != S_IDLE && (next_op inside {OP_PROG, OP_ERASE}));
    next_port = shared_byte_port_o;
    if (wr_state && !next_ph)
    begin
      if (next_state == S_CMD1)
        next_port = plan.cmd1;
      else if (next_state == S_CMD2)
        next_port = plan.cmd2;
      else if (next_state == S_ADDR)
        next_port = addr_byte(next_cnt);
      else
        next_port = mem_rd;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state                 <= S_IDLE;
      op                    <= OP_STATUS;
      ph                    <= 1'b0;
      cnt                   <= '0;
      xfer_len              <= '0;
      ptr                   <= '0;
      last_byte             <= 8'h00;
      chip_select_n_o       <= 1'b1;
      cmd_latch_o           <= 1'b0;
      addr_latch_o          <= 1'b0;
      write_strobe_n_o      <= 1'b1;
      output_strobe_n_o     <= 1'b1;
      write_protect_n_o     <= 1'b0;
      shared_byte_port_o    <= 8'h00;
      shared_byte_port_oe_o <= 1'b0;
    end
    else
    begin
      state                 <= next_state;
      op                    <= next_op;
      ph                    <= next_ph;
      cnt                   <= next_cnt;
      xfer_len              <= next_len;
      ptr                   <= next_ptr;
      last_byte             <= next_last;
      chip_select_n_o       <= next_cs_n;
      cmd_latch_o           <= next_cle;
      addr_latch_o          <= next_ale;
      write_strobe_n_o      <= next_we_n;
      output_strobe_n_o     <= next_re_n;
      write_protect_n_o     <= next_wp_n;
      shared_byte_port_o    <= next_port;
      shared_byte_port_oe_o <= next_oe;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_wp_held_pe: assert property ((!idle && (op inside {OP_PROG, OP_ERASE}))
    |-> write_protect_n_o) else $error("write protect low during P/E");
  a_addr_hi_pad: assert property ((addr_latch_o && !write_strobe_n_o && op != OP_ID
    && cnt[1:0] == AB_COL_HI) |-> shared_byte_port_o[7:4] == COL_HI_PAD)
    else $error("column high byte not padded");
  a_wstrobe_kind: assert property (!write_strobe_n_o |-> output_strobe_n_o
    && !chip_select_n_o && !(cmd_latch_o && addr_latch_o) ##1 write_strobe_n_o)
    else $error("bad write strobe cycle");
  a_read_no_drive: assert property (!output_strobe_n_o |-> !shared_byte_port_oe_o
    && !cmd_latch_o && !addr_latch_o && write_strobe_n_o)
    else $error("port driven in read cycle");
  a_read_go_addr: assert property ((cmd_latch_o && !write_strobe_n_o
    && shared_byte_port_o == CMD_READ_GO) |-> $past(addr_latch_o, 2)
    && op == OP_READ) else $error("read start without address");
  a_col_go_addr: assert property ((cmd_latch_o && !write_strobe_n_o
    && shared_byte_port_o == CMD_COL_GO) |-> $past(addr_latch_o, 2)
    && !$past(addr_latch_o, 6)) else $error("column change not two bytes");
  a_prog_go_data: assert property ((cmd_latch_o && !write_strobe_n_o
    && shared_byte_port_o == CMD_PROG_GO) |-> $past(shared_byte_port_oe_o, 2)
    && !$past(cmd_latch_o, 2)) else $error("program start out of order");
  a_erase_go_wait: assert property ((cmd_latch_o && !write_strobe_n_o
    && shared_byte_port_o == CMD_ERASE_GO) |=> write_strobe_n_o
    ##1 (state == S_WAIT_WB && !cmd_latch_o)) else $error("erase not waited");
  a_busy_cmd_only: assert property ((start_go && !ready_busy_n_i)
    |-> (start_op inside {OP_STATUS, OP_RESET}) ##1 state == S_SETUP)
    else $error("command issued while busy");

  c_read_done: cover property (state == S_RDATA && op == OP_READ ##1 idle);
  c_prog_go: cover property (state == S_CMD2 && op == OP_PROG);
  c_erase_wait: cover property (state == S_WAIT_RDY && op == OP_ERASE);
  c_refused: cover property (start_req && start_bad);

endmodule

`default_nettype wire

// ===== testbench/nfp_flash_model.sv
/* Behavioural page-flash device seen from the host's pins.
   Assumes the bench resolves busy_o onto a pulled-up ready line. */
`timescale 1ns/10ps
`default_nettype none
module nfp_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h5a, // Arbitrary value
  parameter int         BUSY_NS = 1000
) (
  input  wire logic       cs_n_i,
  input  wire logic       cle_i,
  input  wire logic       ale_i,
  input  wire logic       we_n_i,
  input  wire logic       re_n_i,
  input  wire logic       wp_n_i,
  input  wire logic [7:0] dq_i,
  output logic      [7:0] dq_o,
  output logic            busy_o = 1'b0
);
  logic [11:0] col = 0;
  logic [15:0] row = 0;
  logic [7:0]  cmd = 0, last = 0, idx = 0;
  logic [1:0]  ab = 0;
  logic [3:0]  pe = 0;
  always @(posedge we_n_i)
    if (!cs_n_i && re_n_i && cle_i && !ale_i
        && (!busy_o || dq_i inside {8'h70, 8'hff}))
    begin
      cmd = dq_i;
      ab = 2'h0;
      idx = 8'h0;
      // Busy runs out on its own; chip select high cannot end it
      if (dq_i inside {8'h30, 8'hff}
          || (dq_i inside {8'h10, 8'hd0} && wp_n_i))
      begin
        pe = pe + 4'(dq_i inside {8'h10, 8'hd0});
        busy_o = 1'b1;
        busy_o <= #(BUSY_NS) 1'b0;
      end
    end
  always @(posedge we_n_i)
    if (!cs_n_i && re_n_i && ale_i && !cle_i && !busy_o)
    begin
      case (ab)
        2'h0: col[7:0] = dq_i;
        2'h1: col[11:8] = dq_i[3:0];
        2'h2: row[7:0] = dq_i;
        default: row[15:8] = dq_i;
      endcase
      ab = ab + 2'h1;
    end
  always @(negedge re_n_i)
    if (!cs_n_i && !busy_o)
    begin
      last = cmd == 8'h70 ? {wp_n_i, 3'h0, pe}
           : cmd == 8'h90 ? ID_CODE + idx : col[7:0] ^ row[7:0];
      idx = idx + 8'h1;
      col = col == 12'd2111 ? 12'h0 : col + 12'h1;
    end
  // Released port shows the inverse so a stale byte cannot pass
  assign dq_o = (!cs_n_i && !re_n_i && !cle_i && !ale_i && we_n_i && !busy_o)
              ? last : ~last;
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
/* Self-checking bench: AHB-Lite master driving nfp_host against the flash model.
   Assumes hready is fed back from the slave and busy has a pull-up. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import nfp_pkg::*;
  typedef struct packed {logic [2:0] op; logic [11:0] col; logic [15:0] row;
    logic [6:0] n; logic [7:0] x;} nfp_case_t;
  localparam logic [7:0] ID_VAL = 8'h5a; // Arbitrary value
  logic        clk_i = 0, reset_n_i = 0, hsel_i = 0, hwrite_i = 0, hreadyout_o;
  logic        cs_n, cle, ale, we_n, re_n, wp_n, busy, oe, hresp, hold = 0;
  logic [1:0]  htrans_i = 0;
  logic [2:0]  hsize_i = HSIZE_WORD;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, q = 0;
  logic [7:0]  dq_h, dq_d;
  int          errors = 0, check_count = 0;
  nfp_case_t   cases [8] = '{'{3'h0, 12'h003, 16'h0041, 7'h2, 8'h0},
    '{3'h0, 12'h83f, 16'h1234, 7'h2, 8'h0}, '{3'h6, 12'h010, 16'h1234, 7'h1, 8'h0},
    '{3'h5, 12'h0, 16'h0, 7'h2, ID_VAL}, '{3'h2, 12'h0, 16'h0040, 7'h0, 8'h0},
    '{3'h1, 12'h0, 16'h0041, 7'h1, 8'h0}, '{3'h4, 12'h0, 16'h0, 7'h0, 8'h0},
    '{3'h3, 12'h0, 16'h0, 7'h1, 8'h82}};
  // Hold stands for a second open-drain device pulling the busy line low
  nfp_host uut (.clk_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o(hresp), .hrdata_o,
    .chip_select_n_o(cs_n), .cmd_latch_o(cle), .addr_latch_o(ale), .write_strobe_n_o(we_n),
    .output_strobe_n_o(re_n), .write_protect_n_o(wp_n), .shared_byte_port_i(dq_d),
    .shared_byte_port_o(dq_h), .shared_byte_port_oe_o(oe), .ready_busy_n_i(!busy && !hold));
  // Undriven port shows the inverse, so a missing enable corrupts the byte
  nfp_flash_model #(.ID_CODE(ID_VAL)) dev (.cs_n_i(cs_n), .cle_i(cle), .ale_i(ale),
    .we_n_i(we_n), .re_n_i(re_n), .wp_n_i(wp_n), .dq_i(oe ? dq_h : ~dq_h), .dq_o(dq_d),
    .busy_o(busy));
  initial forever #25 clk_i = ~clk_i;
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  // Hready seen just before the edge equals what that edge samples
  task automatic wait_rdy;
    logic r;
    do
    begin
      @(negedge clk_i) r = hreadyout_o;
      q = hrdata_o;
      @(posedge clk_i);
    end while (r !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= a;
    wait_rdy;
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_rdy;
  endtask
  function automatic logic [7:0] expb(input nfp_case_t c, input int i);
    logic [11:0] k;
    k = 12'((int'(c.col) + i) % 2112);
    if (c.op == 3'h5)
      return c.x + 8'(i);
    if (c.op == 3'h3)
      return c.x;
    return k[7:0] ^ c.row[7:0];
  endfunction
  task automatic run(input nfp_case_t c);
    bus(1'b1, REG_COLUMN, 32'(c.col));
    bus(1'b1, REG_ROW, 32'(c.row));
    bus(1'b1, REG_COUNT, 32'(c.n));
    bus(1'b1, REG_BUF_PTR, 32'h0);
    for (int i = 0; i < int'(c.n) && c.op == 3'h1; i++)
      bus(1'b1, REG_BUF_DATA, 32'(expb(c, i)));
    bus(1'b1, REG_START, 32'(c.op));
    q = 32'h1;
    for (int i = 0; i < 300 && q[0] !== 1'b0; i++)
      bus(1'b0, REG_STATUS, 32'h0);
    chk("done", 32'h1, 32'(q[3]));
    if (c.n != 7'h0 && c.op != 3'h1)
      chk("last", 32'(expb(c, int'(c.n) - 1)), 32'(q[15:8]));
    bus(1'b1, REG_STATUS, 32'hc);
    bus(1'b1, REG_BUF_PTR, 32'h0);
    for (int i = 0; i < int'(c.n); i++)
    begin
      bus(1'b0, REG_BUF_DATA, 32'h0);
      chk("byte", 32'(expb(c, i)), 32'(q[7:0]));
    end
    $display("test op %0d done", c.op);
  endtask
  initial
  begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    chk("cs idle", 32'h1, 32'(cs_n));
    chk("wp idle", 32'h0, 32'(wp_n));
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", 32'h0, q);
    chk("hresp", 32'h0, 32'(hresp));
    bus(1'b0, 32'h40, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
    bus(1'b1, REG_CTRL, 32'h1);
    foreach (cases[i])
      run(cases[i]);
    bus(1'b1, REG_CTRL, 32'h0);
    bus(1'b1, REG_START, 32'h1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("refused", 32'h1, 32'(q[2]));
    bus(1'b1, REG_STATUS, 32'h4);
    bus(1'b1, REG_START, 32'h7);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("bad op", 32'h6, 32'(q[3:0]));
    $display("test protect done");
    bus(1'b1, REG_STATUS, 32'h4);
    hold <= 1'b1;
    bus(1'b1, REG_START, 32'h0);
    bus(1'b1, REG_START, 32'h3);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("busy start", 32'h5, 32'(q[3:0]));
    $display("test busy line done");
    complete_run;
  end
  initial
  begin
    #2000000;
    errors++;
    complete_run;
  end
endmodule
`default_nettype wire
